/* File: include/phy_mgmt_pkg.sv */
// Shared constants and types of the PHY management register bank
package phy_mgmt_pkg;

  // ----------------------------------------------------------------
  // Access port widths
  // ----------------------------------------------------------------
  localparam int IDX_W  = 5;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_STAT = 5'h01;
  localparam logic [4:0] IDX_IDHI = 5'h02;
  localparam logic [4:0] IDX_IDLO = 5'h03;
  localparam logic [4:0] IDX_ADV  = 5'h04;

  // ----------------------------------------------------------------
  // Basic control bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_RST        = 15;
  localparam int CTRL_LOOP       = 14;
  localparam int CTRL_SPEED      = 13;
  localparam int CTRL_AN_EN      = 12;
  localparam int CTRL_PDOWN      = 11;
  localparam int CTRL_AN_RESTART = 9;
  localparam int CTRL_DUPLEX     = 8;
  localparam int CTRL_COL_TEST   = 7;

  // ----------------------------------------------------------------
  // Basic status bit positions
  // ----------------------------------------------------------------
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_RFAULT  = 4;
  localparam int STAT_LINK    = 2;
  localparam int STAT_JABBER  = 1;

  // ----------------------------------------------------------------
  // Advertisement field positions
  // ----------------------------------------------------------------
  localparam int ADV_RFAULT   = 13;
  localparam int ADV_PAUSE_HI = 11;
  localparam int ADV_PAUSE_LO = 10;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_WR_MASK     = 16'hf980;
  localparam logic [15:0] CTRL_RESET       = 16'h3100;
  localparam logic [15:0] CTRL_IMMUNE_MASK = 16'h0000;
  localparam logic [15:0] STAT_CONST       = 16'h7809;
  localparam logic [15:0] ADV_WR_MASK      = 16'h2dff;
  localparam logic [15:0] ADV_RESET        = 16'h01e1;
  localparam logic [15:0] ADV_IMMUNE_MASK  = 16'h0000;

  // ----------------------------------------------------------------
  // Pause encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PAUSE_NONE = 2'b00;
  localparam logic [1:0] PAUSE_SYM  = 2'b01;
  localparam logic [1:0] PAUSE_ASYM = 2'b10;
  localparam logic [1:0] PAUSE_BOTH = 2'b11;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 5;
  localparam int SOFT_RST_NS     = 100;
  localparam int SOFT_RST_CYCLES = (SOFT_RST_NS + CLK_NS - 1) / CLK_NS;

  // Soft reset sequencer states, Gray along the path
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_HOLD = 2'b01,
    RS_DONE = 2'b11
  } rst_state_t;

endpackage

/* File: logic/sync_2ff.sv */
// Two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] stab_ff;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      stab_ff <= '0;
    end else begin
      meta_ff <= async_in;
      stab_ff <= meta_ff;
    end
  end

  assign sync_out = stab_ff;

endmodule // sync_2ff
`default_nettype wire

/* File: logic/soft_reset_timer.sv */
// Sequencer that holds the soft reset for a fixed number of cycles
`timescale 1ns/100ps
`default_nettype none
module soft_reset_timer #(
  parameter int CYCLES = phy_mgmt_pkg::SOFT_RST_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CNT_W = $clog2(CYCLES + 1);

  phy_mgmt_pkg::rst_state_t state_ff;
  phy_mgmt_pkg::rst_state_t nxt_state;
  logic [CNT_W-1:0]         cnt_ff;
  logic [CNT_W-1:0]         nxt_cnt;
  logic                     done_ff;
  logic                     nxt_done;

  // Next state; a start while busy is ignored
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      phy_mgmt_pkg::RS_IDLE: begin
        if (start) begin
          nxt_state = phy_mgmt_pkg::RS_HOLD;
          nxt_cnt   = '0;
        end
      end
      phy_mgmt_pkg::RS_HOLD: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff == CNT_W'(CYCLES - 1)) begin
          nxt_state = phy_mgmt_pkg::RS_DONE;
          nxt_done  = 1'b1;
        end
      end
      phy_mgmt_pkg::RS_DONE: begin
        nxt_state = phy_mgmt_pkg::RS_IDLE;
      end
      default: begin
        nxt_state = phy_mgmt_pkg::RS_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= phy_mgmt_pkg::RS_IDLE;
      cnt_ff   <= '0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      done_ff  <= nxt_done;
    end
  end

  assign busy = (state_ff != phy_mgmt_pkg::RS_IDLE);
  assign done = done_ff;

endmodule // soft_reset_timer
`default_nettype wire

/* File: logic/phy_mgmt_register_bank.sv */
// Management register bank of a 10/100 PHY, reached by register index
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Bank has no memory address; reached only through MAC indexed control and data.
// - Immune fields survive a soft reset but return to defaults on hardware reset.
// - Writing control bit 15 starts soft reset; bit clears itself when finished.
// - Control bit 14 selects loopback; resets to 0.
// - Bit 13 picks 100/10 Mbps, bit 8 full/half duplex; ignored under autoneg.
// - Control bit 12 enables autoneg, overrides manual speed and duplex; resets to 1.
// - Bit 11 powers down; after clearing, autoneg may finish and set status bit 5.
// - Writing control bit 9 restarts autoneg; bit clears itself and reads 0.
// - Control bit 7 enables the collision test; resets to 0.
// - Status bits 14 to 11 read 1, bit 15 reads 0.
// - Status bit 5 shows autoneg complete; read-only, resets to 0.
// - Status bit 4 latches high on remote fault; resets to 0.
// - Status bit 2 shows link, latches low on loss; resets to 0.
// - Status bit 1 latches high on jabber; resets to 0.
// - Status bits 3 and 0 read constant 1.
// - Identifier registers return OUI bits, six-bit model and four-bit revision.
// - Advertisement bit 13 is writable remote fault flag; resets to 0.
// - Advertisement bits 11:10 encode pause capability; reset to 00.
// - With both pause types advertised, adopt at most one on completion.
// - Advertisement bits 8 to 5 reset to 1; selector 4:0 resets to 00001.
module phy_mgmt_register_bank #(
  parameter logic [15:0] OUI_HI   = 16'h1234, // Arbitrary value
  parameter logic [5:0]  OUI_LO   = 6'h2a,    // Arbitrary value
  parameter logic [5:0]  MODEL_NO = 6'h05,    // Arbitrary value
  parameter logic [3:0]  REV_NO   = 4'h1,     // Arbitrary value
  parameter int          RST_CYC  = phy_mgmt_pkg::SOFT_RST_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  acc_index,
  input  wire logic [15:0] acc_wr_data,
  input  wire logic        acc_wr_en,
  input  wire logic        acc_rd_en,
  output logic      [15:0] acc_rd_data,
  output logic             acc_rd_valid,
  input  wire logic        link_up_in,
  input  wire logic        remote_fault_in,
  input  wire logic        jabber_in,
  input  wire logic        an_done_in,
  input  wire logic        neg_speed_100_in,
  input  wire logic        neg_full_duplex_in,
  output logic             soft_reset_active,
  output logic             loopback_en,
  output logic             speed_100,
  output logic             full_duplex,
  output logic             an_enable,
  output logic             power_down,
  output logic             an_restart,
  output logic             col_test_en,
  output logic      [15:0] adv_word,
  output logic             pause_sym,
  output logic             pause_asym
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [5:0]  cond_s;
  logic        link_s;
  logic        rfault_s;
  logic        jab_s;
  logic        an_done_s;
  logic        nspeed_s;
  logic        nduplex_s;
  logic        rst_start;
  logic        rst_busy;
  logic        rst_done;
  logic        wr_ctrl;
  logic        wr_adv;
  logic        rd_stat;
  logic [15:0] ctrl_ff;
  logic [15:0] nxt_ctrl;
  logic [15:0] adv_ff;
  logic [15:0] nxt_adv;
  logic        restart_ff;
  logic        nxt_restart;
  logic        rf_lh_ff;
  logic        nxt_rf_lh;
  logic        jab_lh_ff;
  logic        nxt_jab_lh;
  logic        link_ll_ff;
  logic        nxt_link_ll;
  logic        speed_ff;
  logic        nxt_speed;
  logic        duplex_ff;
  logic        nxt_duplex;
  logic        psym_ff;
  logic        nxt_psym;
  logic        pasym_ff;
  logic        nxt_pasym;
  logic        an_cmpl;
  logic [15:0] stat_word;
  logic [15:0] rd_word;
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;
  logic        rd_valid_ff;

  // Index decode shared by the read and write paths
  function automatic logic idx_hit(input logic [4:0] idx,
                                   input logic [4:0] tgt,
                                   input logic       en);
    idx_hit = en && (idx == tgt);
  endfunction

  // ----------------------------------------------------------------
  // Condition inputs from the analog side
  // ----------------------------------------------------------------
  sync_2ff #(
    .W (6)
  ) u_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in ({link_up_in, remote_fault_in, jabber_in, an_done_in,
                neg_speed_100_in, neg_full_duplex_in}),
    .sync_out (cond_s)
  );

  assign {link_s, rfault_s, jab_s, an_done_s, nspeed_s, nduplex_s} = cond_s;

  // ----------------------------------------------------------------
  // Soft reset sequencer
  // ----------------------------------------------------------------
  soft_reset_timer #(
    .CYCLES (RST_CYC)
  ) u_rst (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (rst_start),
    .busy    (rst_busy),
    .done    (rst_done)
  );

  // Indexed access decode; nothing here is memory mapped
  assign wr_ctrl = idx_hit(acc_index, phy_mgmt_pkg::IDX_CTRL, acc_wr_en);
  assign wr_adv  = idx_hit(acc_index, phy_mgmt_pkg::IDX_ADV, acc_wr_en);
  assign rd_stat = idx_hit(acc_index, phy_mgmt_pkg::IDX_STAT, acc_rd_en);

  // A second start while busy would be lost, so only start from idle
  assign rst_start = wr_ctrl && acc_wr_data[phy_mgmt_pkg::CTRL_RST]
                     && !ctrl_ff[phy_mgmt_pkg::CTRL_RST] && !rst_busy;

  // ----------------------------------------------------------------
  // Control and advertisement registers
  // ----------------------------------------------------------------
  // Writes during a soft reset are dropped; the host should not mix bits
  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_adv     = adv_ff;
    nxt_restart = 1'b0;
    if (rst_done) begin
      nxt_ctrl = (ctrl_ff & phy_mgmt_pkg::CTRL_IMMUNE_MASK)
               | (phy_mgmt_pkg::CTRL_RESET & ~phy_mgmt_pkg::CTRL_IMMUNE_MASK);
      nxt_adv  = (adv_ff & phy_mgmt_pkg::ADV_IMMUNE_MASK)
               | (phy_mgmt_pkg::ADV_RESET & ~phy_mgmt_pkg::ADV_IMMUNE_MASK);
    end else if (!ctrl_ff[phy_mgmt_pkg::CTRL_RST]) begin
      if (wr_ctrl) begin
        nxt_ctrl    = acc_wr_data & phy_mgmt_pkg::CTRL_WR_MASK;
        nxt_restart = acc_wr_data[phy_mgmt_pkg::CTRL_AN_RESTART];
      end
      if (wr_adv) begin
        nxt_adv = acc_wr_data & phy_mgmt_pkg::ADV_WR_MASK;
      end
    end
  end

  // Hardware reset returns every field, immune or not, to default
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff    <= phy_mgmt_pkg::CTRL_RESET;
      adv_ff     <= phy_mgmt_pkg::ADV_RESET;
      restart_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      adv_ff     <= nxt_adv;
      restart_ff <= nxt_restart;
    end
  end

  // ----------------------------------------------------------------
  // Latched status bits
  // ----------------------------------------------------------------
  // A read reloads from the live condition, so an event in the read cycle wins
  always_comb begin
    nxt_rf_lh   = rf_lh_ff | rfault_s;
    nxt_jab_lh  = jab_lh_ff | jab_s;
    nxt_link_ll = link_ll_ff & link_s;
    if (rd_stat) begin
      nxt_rf_lh   = rfault_s;
      nxt_jab_lh  = jab_s;
      nxt_link_ll = link_s;
    end
    // Soft reset clears the latches, but a fault present that cycle still sets
    if (rst_done) begin
      nxt_rf_lh   = rfault_s;
      nxt_jab_lh  = jab_s;
      nxt_link_ll = 1'b0;
    end
  end

  // Latch registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rf_lh_ff   <= 1'b0;
      jab_lh_ff  <= 1'b0;
      link_ll_ff <= 1'b0;
    end else begin
      rf_lh_ff   <= nxt_rf_lh;
      jab_lh_ff  <= nxt_jab_lh;
      link_ll_ff <= nxt_link_ll;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode results
  // ----------------------------------------------------------------
  // Completion only counts while autoneg runs and the PHY is powered
  assign an_cmpl = an_done_s && ctrl_ff[phy_mgmt_pkg::CTRL_AN_EN]
                   && !ctrl_ff[phy_mgmt_pkg::CTRL_PDOWN];

  // Autoneg result overrides the manual bits; both pause types give symmetric
  always_comb begin
    nxt_speed  = ctrl_ff[phy_mgmt_pkg::CTRL_SPEED];
    nxt_duplex = ctrl_ff[phy_mgmt_pkg::CTRL_DUPLEX];
    nxt_psym   = 1'b0;
    nxt_pasym  = 1'b0;
    if (ctrl_ff[phy_mgmt_pkg::CTRL_AN_EN]) begin
      nxt_speed  = nspeed_s;
      nxt_duplex = nduplex_s;
    end
    if (an_cmpl) begin
      case (adv_ff[phy_mgmt_pkg::ADV_PAUSE_HI:phy_mgmt_pkg::ADV_PAUSE_LO])
        phy_mgmt_pkg::PAUSE_SYM:  nxt_psym  = 1'b1;
        phy_mgmt_pkg::PAUSE_ASYM: nxt_pasym = 1'b1;
        phy_mgmt_pkg::PAUSE_BOTH: nxt_psym  = 1'b1;
        default:                  nxt_psym  = 1'b0;
      endcase
    end
  end

  // Mode result registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      speed_ff  <= 1'b0;
      duplex_ff <= 1'b0;
      psym_ff   <= 1'b0;
      pasym_ff  <= 1'b0;
    end else begin
      speed_ff  <= nxt_speed;
      duplex_ff <= nxt_duplex;
      psym_ff   <= nxt_psym;
      pasym_ff  <= nxt_pasym;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Status word: constant abilities plus live and latched bits
  always_comb begin
    stat_word = phy_mgmt_pkg::STAT_CONST;
    stat_word[phy_mgmt_pkg::STAT_AN_DONE] = an_cmpl;
    stat_word[phy_mgmt_pkg::STAT_RFAULT]  = rf_lh_ff;
    stat_word[phy_mgmt_pkg::STAT_LINK]    = link_ll_ff;
    stat_word[phy_mgmt_pkg::STAT_JABBER]  = jab_lh_ff;
  end

  // Read mux; unmapped indexes read zero
  always_comb begin
    rd_word = 16'h0000;
    if (acc_index == phy_mgmt_pkg::IDX_CTRL) begin
      rd_word = ctrl_ff;
      rd_word[phy_mgmt_pkg::CTRL_AN_RESTART] = restart_ff;
    end else if (acc_index == phy_mgmt_pkg::IDX_STAT) begin
      rd_word = stat_word;
    end else if (acc_index == phy_mgmt_pkg::IDX_IDHI) begin
      rd_word = OUI_HI;
    end else if (acc_index == phy_mgmt_pkg::IDX_IDLO) begin
      rd_word = {OUI_LO, MODEL_NO, REV_NO};
    end else if (acc_index == phy_mgmt_pkg::IDX_ADV) begin
      rd_word = adv_ff;
    end
    nxt_rd_data = acc_rd_en ? rd_word : rd_data_ff;
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_ff  <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= acc_rd_en;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken from flip-flops
  // ----------------------------------------------------------------
  assign acc_rd_data       = rd_data_ff;
  assign acc_rd_valid      = rd_valid_ff;
  assign soft_reset_active = ctrl_ff[phy_mgmt_pkg::CTRL_RST];
  assign loopback_en       = ctrl_ff[phy_mgmt_pkg::CTRL_LOOP];
  assign speed_100         = speed_ff;
  assign full_duplex       = duplex_ff;
  assign an_enable         = ctrl_ff[phy_mgmt_pkg::CTRL_AN_EN];
  assign power_down        = ctrl_ff[phy_mgmt_pkg::CTRL_PDOWN];
  assign an_restart        = restart_ff;
  assign col_test_en       = ctrl_ff[phy_mgmt_pkg::CTRL_COL_TEST];
  assign adv_word          = adv_ff;
  assign pause_sym         = psym_ff;
  assign pause_asym        = pasym_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_rst_start;
    @(posedge clk_sys) disable iff (sys_rst)
    rst_start |=> soft_reset_active;
  endproperty
  a_rst_start: assert property (p_rst_start)
    else $error("soft reset bit did not set");

  property p_rst_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(soft_reset_active) |-> soft_reset_active [*2] ##[1:400] !soft_reset_active;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("soft reset bit did not self-clear");

  property p_rst_done;
    @(posedge clk_sys) disable iff (sys_rst)
    rst_done |=> !soft_reset_active;
  endproperty
  a_rst_done: assert property (p_rst_done)
    else $error("soft reset bit still set after the sequence ended");

  property p_loop;
    @(posedge clk_sys) disable iff (sys_rst)
    (wr_ctrl && !soft_reset_active && !rst_done)
      |=> (loopback_en == $past(acc_wr_data[phy_mgmt_pkg::CTRL_LOOP]));
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback bit not written");

  property p_restart;
    @(posedge clk_sys) disable iff (sys_rst)
    an_restart |=> !an_restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart bit did not self-clear");

  property p_stat_const;
    @(posedge clk_sys) disable iff (sys_rst)
    rd_stat |=> (acc_rd_data[15:11] == 5'h0f) && acc_rd_valid;
  endproperty
  a_stat_const: assert property (p_stat_const)
    else $error("ability bits wrong");

  property p_ext_cap;
    @(posedge clk_sys) disable iff (sys_rst)
    rd_stat |=> acc_rd_data[3] && acc_rd_data[0];
  endproperty
  a_ext_cap: assert property (p_ext_cap)
    else $error("autoneg or extended ability bit low");

  property p_pause_one;
    @(posedge clk_sys) disable iff (sys_rst)
    !(pause_sym && pause_asym);
  endproperty
  a_pause_one: assert property (p_pause_one)
    else $error("both pause settings adopted");

  property p_rsvd;
    @(posedge clk_sys) disable iff (sys_rst)
    (acc_rd_en && acc_index == phy_mgmt_pkg::IDX_CTRL)
      |=> (acc_rd_data[10] == 1'b0) && (acc_rd_data[6:0] == 7'h00);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved control bits read nonzero");

  property p_fault_lh;
    @(posedge clk_sys) disable iff (sys_rst)
    (rfault_s && !rst_done) |=> rf_lh_ff;
  endproperty
  a_fault_lh: assert property (p_fault_lh)
    else $error("remote fault not latched");

  property p_link_ll;
    @(posedge clk_sys) disable iff (sys_rst)
    !link_s |=> !link_ll_ff;
  endproperty
  a_link_ll: assert property (p_link_ll)
    else $error("link loss not latched low");

endmodule // phy_mgmt_register_bank
`default_nettype wire

/* File: test/mac_access_model.sv */
// Behavioural MAC side of the indexed PHY management access
`timescale 1ns/100ps
`default_nettype none
module mac_access_model (
  input  wire logic        clk_sys,
  output logic      [4:0]  acc_index,
  output logic      [15:0] acc_wr_data,
  output logic             acc_wr_en,
  output logic             acc_rd_en,
  input  wire logic [15:0] acc_rd_data,
  input  wire logic        acc_rd_valid
);
  // Idle bus at time zero
  initial begin
    acc_index = 5'h00;
    acc_wr_data = 16'h0000;
    acc_wr_en = 1'b0;
    acc_rd_en = 1'b0;
  end

  // One write per strobe pulse; data inverted once released
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    @(posedge clk_sys);
    acc_index   <= idx;
    acc_wr_data <= d;
    acc_wr_en   <= 1'b1;
    @(posedge clk_sys);
    acc_wr_en   <= 1'b0;
    acc_wr_data <= ~d;
  endtask

  // Answer is taken one edge after the strobe is taken
  task automatic rd(input logic [4:0] idx, output logic [15:0] d, output logic ok);
    @(posedge clk_sys);
    acc_index <= idx;
    acc_rd_en <= 1'b1;
    @(posedge clk_sys);
    acc_rd_en <= 1'b0;
    @(posedge clk_sys);
    ok = acc_rd_valid;
    d  = acc_rd_data;
  endtask
endmodule // mac_access_model
`default_nettype wire

/* File: test/phy_mgmt_register_bank_test.sv */
// Self-checking bench of the PHY management register bank
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_register_bank_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] acc_index;
  logic [15:0] acc_wr_data, acc_rd_data, adv_word;
  logic acc_wr_en, acc_rd_en, acc_rd_valid;
  logic link_up_in = 1'b0, remote_fault_in = 1'b0, jabber_in = 1'b0;
  logic an_done_in = 1'b0, neg_speed_100_in = 1'b0, neg_full_duplex_in = 1'b0;
  logic soft_reset_active, loopback_en, speed_100, full_duplex, an_enable;
  logic power_down, an_restart, col_test_en, pause_sym, pause_asym;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  // Short soft reset keeps the run brief
  phy_mgmt_register_bank #(.RST_CYC(2)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .acc_index(acc_index), .acc_wr_data(acc_wr_data), .acc_wr_en(acc_wr_en),
    .acc_rd_en(acc_rd_en), .acc_rd_data(acc_rd_data), .acc_rd_valid(acc_rd_valid),
    .link_up_in(link_up_in), .remote_fault_in(remote_fault_in), .jabber_in(jabber_in),
    .an_done_in(an_done_in), .neg_speed_100_in(neg_speed_100_in),
    .neg_full_duplex_in(neg_full_duplex_in), .soft_reset_active(soft_reset_active),
    .loopback_en(loopback_en), .speed_100(speed_100), .full_duplex(full_duplex),
    .an_enable(an_enable), .power_down(power_down), .an_restart(an_restart),
    .col_test_en(col_test_en), .adv_word(adv_word), .pause_sym(pause_sym),
    .pause_asym(pause_asym));

  mac_access_model i_mac (.clk_sys(clk_sys), .acc_index(acc_index),
    .acc_wr_data(acc_wr_data), .acc_wr_en(acc_wr_en), .acc_rd_en(acc_rd_en),
    .acc_rd_data(acc_rd_data), .acc_rd_valid(acc_rd_valid));

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard, far above the roughly 135 cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [15:0] z(input logic b);
    return {15'h0000, b};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [4:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    i_mac.rd(idx, d, ok);
    chk("rd_valid", z(ok), 16'h0001);
    chk($sformatf("reg %0d", idx), d, exp);
  endtask

  task automatic t_reset();
    rchk(phy_mgmt_pkg::IDX_CTRL, 16'h3100);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h7809);
    rchk(phy_mgmt_pkg::IDX_IDHI, 16'h1234);
    rchk(phy_mgmt_pkg::IDX_IDLO, {6'h2a, 6'h05, 4'h1});
    rchk(phy_mgmt_pkg::IDX_ADV, 16'h01e1);
    rchk(5'h05, 16'h0000);
    $display("test reset values done");
  endtask

  task automatic t_write();
    i_mac.wr(phy_mgmt_pkg::IDX_CTRL, 16'h4cff);
    cyc(1);
    chk("loopback", z(loopback_en), 16'h0001);
    chk("power_down", z(power_down), 16'h0001);
    chk("col_test", z(col_test_en), 16'h0001);
    chk("an_enable", z(an_enable), 16'h0000);
    rchk(phy_mgmt_pkg::IDX_CTRL, 16'h4880);
    i_mac.wr(phy_mgmt_pkg::IDX_ADV, 16'hffff);
    rchk(phy_mgmt_pkg::IDX_ADV, 16'h2dff);
    chk("adv_word", adv_word, 16'h2dff);
    i_mac.wr(phy_mgmt_pkg::IDX_IDHI, 16'h0000);
    rchk(phy_mgmt_pkg::IDX_IDHI, 16'h1234);
    i_mac.wr(phy_mgmt_pkg::IDX_CTRL, 16'h1200);
    cyc(1);
    chk("an_restart", z(an_restart), 16'h0001);
    cyc(1);
    chk("an_restart", z(an_restart), 16'h0000);
    rchk(phy_mgmt_pkg::IDX_CTRL, 16'h1000);
    $display("test writes done");
  endtask

  task automatic t_latch();
    link_up_in <= 1'b1;
    cyc(4);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h7809);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h780d);
    remote_fault_in <= 1'b1;
    jabber_in <= 1'b1;
    link_up_in <= 1'b0;
    cyc(4);
    remote_fault_in <= 1'b0;
    jabber_in <= 1'b0;
    link_up_in <= 1'b1;
    cyc(4);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h781b);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h780d);
    $display("test latched status done");
  endtask

  task automatic t_pause();
    logic [1:0] code;
    i_mac.wr(phy_mgmt_pkg::IDX_ADV, 16'h0de1);
    an_done_in <= 1'b1;
    neg_speed_100_in <= 1'b1;
    cyc(5);
    chk("pause_both", {14'h0, pause_asym, pause_sym}, 16'h0001);
    chk("speed", {14'h0, speed_100, full_duplex}, 16'h0002);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h782d);
    for (int i = 0; i < 3; i++) begin
      code = 2'(i);
      i_mac.wr(phy_mgmt_pkg::IDX_ADV, {4'h0, code, 10'h1e1});
      cyc(2);
      chk("pause", {14'h0, pause_asym, pause_sym}, {14'h0, code[1], code[0]});
    end
    i_mac.wr(phy_mgmt_pkg::IDX_CTRL, 16'h0100);
    cyc(2);
    chk("manual", {14'h0, speed_100, full_duplex}, 16'h0001);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h780d);
    i_mac.wr(phy_mgmt_pkg::IDX_CTRL, 16'h1800);
    cyc(2);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h780d);
    i_mac.wr(phy_mgmt_pkg::IDX_CTRL, 16'h1000);
    cyc(2);
    rchk(phy_mgmt_pkg::IDX_STAT, 16'h782d);
    $display("test pause and speed done");
  endtask

  task automatic t_soft();
    int n;
    n = 0;
    i_mac.wr(phy_mgmt_pkg::IDX_ADV, 16'h2c01);
    i_mac.wr(phy_mgmt_pkg::IDX_CTRL, 16'h8000);
    cyc(1);
    chk("soft_reset", z(soft_reset_active), 16'h0001);
    while (soft_reset_active === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("soft_reset_end", z(n < 40), 16'h0001);
    rchk(phy_mgmt_pkg::IDX_CTRL, 16'h3100);
    rchk(phy_mgmt_pkg::IDX_ADV, 16'h01e1);
    i_mac.wr(phy_mgmt_pkg::IDX_ADV, 16'h2c01);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    rchk(phy_mgmt_pkg::IDX_ADV, 16'h01e1);
    $display("test resets done");
  endtask

  initial begin
    cyc(5);
    sys_rst <= 1'b0;
    t_reset();
    t_write();
    t_latch();
    t_pause();
    t_soft();
    results();
  end
endmodule // phy_mgmt_register_bank_test
`default_nettype wire
